//--- rtl/fsg_gate.sv
// Purpose: erase/write gating by security flags, external and self modes
// Assumes: nv store updates nv_flags_in the cycle after nv_wr_out
// Notes: array ops run outside; this block only decides and reports
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module fsg_gate
  import fsg_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        reset_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        ext_mode_in,
  input  wire logic        ext_cmd_valid_in,
  input  wire fsg_cmd_t    ext_cmd_in,
  output logic             ext_cmd_ready_out,
  output logic             ext_rsp_valid_out,
  output logic             ext_rsp_ack_out,
  input  wire logic [3:0]  nv_flags_in,
  output logic             nv_wr_out,
  output logic      [3:0]  nv_wdata_out,
  output logic             fop_valid_out,
  output fsg_fop_t         fop_out,
  input  wire logic        fop_done_in,
  input  wire logic        fop_ok_in,
  output logic             irq_out
);

  fsg_state_t  state_reg;
  logic [3:0]  active_reg;
  logic        ext_mode_d_reg;
  logic        self_mode_reg;
  logic        self_mode_d_reg;
  logic        self_pend_reg;
  fsg_cmd_t    self_cmd_reg;
  logic [16:0] addr_reg;
  logic        op_ext_reg;
  logic [1:0]  irq_st_reg;
  logic [1:0]  irq_msk_reg;

  logic        wr_acc;
  logic        rd_setup;
  logic        addr_ok;
  logic        session_entry;
  logic        take_ext;
  logic        take_self;
  logic        take;
  fsg_cmd_t    cur;
  logic        touch;
  logic        rej;
  logic        ce_done_ok;
  logic [1:0]  irq_set;

  // ---------------- APB slave, zero wait states
  assign pready_out = 1'b1;
  assign wr_acc     = psel_in && penable_in && pwrite_in && addr_ok;
  assign rd_setup   = psel_in && !penable_in && !pwrite_in;

  always_comb begin
    case (paddr_in)
      OFS_CTRL, OFS_CMD, OFS_ADDR, OFS_STATUS, OFS_IRQ_ST, OFS_IRQ_MSK: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign pslverr_out = psel_in && penable_in && !addr_ok;

  // read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prdata_out <= 32'h0;
    end else if (rd_setup) begin
      case (paddr_in)
        OFS_CTRL:    prdata_out <= {31'h0, self_mode_reg};
        OFS_ADDR:    prdata_out <= {15'h0, addr_reg};
        OFS_STATUS:  prdata_out <= {20'h0, ext_mode_in, self_mode_reg, self_pend_reg,
                                    (state_reg == ST_EXEC), nv_flags_in, active_reg};
        OFS_IRQ_ST:  prdata_out <= {30'h0, irq_st_reg};
        OFS_IRQ_MSK: prdata_out <= {30'h0, irq_msk_reg};
        default:     prdata_out <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      self_mode_reg <= 1'b0;
      addr_reg      <= 17'h0;
      irq_msk_reg   <= IRQ_RST;
    end else if (wr_acc) begin
      if (paddr_in == OFS_CTRL) begin
        self_mode_reg <= pwdata_in[0];
      end
      if (paddr_in == OFS_ADDR) begin
        addr_reg <= pwdata_in[16:0];
      end
      if (paddr_in == OFS_IRQ_MSK) begin
        irq_msk_reg <= pwdata_in[1:0];
      end
    end
  end

  // a command write while one is pending is dropped; software polls pend
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      self_pend_reg <= 1'b0;
      self_cmd_reg  <= '0;
    end else if (wr_acc && paddr_in == OFS_CMD && !self_pend_reg) begin
      self_pend_reg <= 1'b1;
      self_cmd_reg  <= '{op: pwdata_in[2:0], addr: addr_reg, sec: pwdata_in[7:4]};
    end else if (take_self || !self_mode_reg) begin
      self_pend_reg <= 1'b0;
    end
  end

  // ---------------- session entry latches the stored flags
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ext_mode_d_reg  <= 1'b0;
      self_mode_d_reg <= 1'b0;
    end else begin
      ext_mode_d_reg  <= ext_mode_in;
      self_mode_d_reg <= self_mode_reg;
    end
  end

  assign session_entry = (ext_mode_in && !ext_mode_d_reg) ||
                         (self_mode_reg && !self_mode_d_reg);

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      active_reg <= FLAGS_RST; // RULE7
    end else if (session_entry) begin
      active_reg <= nv_flags_in; // RULE1
    end
  end

  // ---------------- command selection and gating
  // ready drops in the entry cycle so a command is never offered and then ignored
  assign ext_cmd_ready_out = (state_reg == ST_IDLE) && ext_mode_in && !session_entry;
  assign take_ext  = ext_cmd_ready_out && ext_cmd_valid_in && !session_entry;
  assign take_self = (state_reg == ST_IDLE) && !ext_mode_in && self_mode_reg &&
                     self_pend_reg && !session_entry;
  assign take      = take_ext || take_self;
  assign cur       = take_ext ? ext_cmd_in : self_cmd_reg;
  assign touch     = (cur.addr <= BOOT_HI);

  always_comb begin
    rej = 1'b0;
    if (take_ext) begin
      case (cur.op)
        OP_CHIP_ER: rej = active_reg[FLG_CE] || active_reg[FLG_BT]; // RULE2 RULE6
        OP_BLK_ER:  rej = active_reg[FLG_CE] || active_reg[FLG_BE] || active_reg[FLG_WR] ||
                          (active_reg[FLG_BT] && touch); // RULE2 RULE4 RULE5 RULE6
        OP_WRITE:   rej = active_reg[FLG_WR] || (active_reg[FLG_BT] && touch); // RULE5 RULE14
        default:    rej = 1'b0;
      endcase
    end else begin
      case (cur.op)
        OP_CHIP_ER: rej = 1'b1; // RULE13
        OP_BLK_ER,
        OP_WRITE:   rej = active_reg[FLG_BT] && touch; // RULE10 RULE11
        default:    rej = 1'b0;
      endcase
    end
  end

  // ---------------- sequencing of array operations
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg     <= ST_IDLE;
      fop_valid_out <= 1'b0;
      fop_out       <= '0;
      op_ext_reg    <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (take && !rej && (cur.op == OP_CHIP_ER || cur.op == OP_BLK_ER ||
                               cur.op == OP_WRITE)) begin
            state_reg     <= ST_EXEC;
            fop_valid_out <= 1'b1;
            fop_out       <= '{op: cur.op, addr: cur.addr};
            op_ext_reg    <= take_ext;
          end
        end
        ST_EXEC: begin
          if (fop_done_in) begin
            state_reg     <= ST_IDLE;
            fop_valid_out <= 1'b0;
          end
        end
        default: begin
          state_reg     <= ST_IDLE;
          fop_valid_out <= 1'b0;
        end
      endcase
    end
  end

  assign ce_done_ok = (state_reg == ST_EXEC) && fop_done_in && fop_ok_in &&
                      op_ext_reg && (fop_out.op == OP_CHIP_ER);

  // ---------------- non-volatile flag updates; flags only grow here, except that a good external chip erase clears block/write locks while FLG_CE is clear
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      nv_wr_out    <= 1'b0;
      nv_wdata_out <= FLAGS_RST;
    end else begin
      nv_wr_out <= 1'b0;
      if (take && cur.op == OP_SEC_SET) begin
        nv_wr_out    <= 1'b1; // RULE17
        nv_wdata_out <= nv_flags_in | cur.sec; // RULE8 RULE12
      end else if (ce_done_ok && !nv_flags_in[FLG_CE]) begin
        nv_wr_out    <= 1'b1; // RULE3
        nv_wdata_out <= nv_flags_in & ~((4'h1 << FLG_BE) | (4'h1 << FLG_WR)); // RULE9 RULE13
      end
    end
  end

  // ---------------- responses
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ext_rsp_valid_out <= 1'b0;
      ext_rsp_ack_out   <= 1'b0;
    end else begin
      ext_rsp_valid_out <= 1'b0;
      if (take_ext && (rej || cur.op == OP_OTHER || cur.op == OP_SEC_SET ||
                       cur.op > OP_SEC_SET)) begin
        ext_rsp_valid_out <= 1'b1; // RULE15
        ext_rsp_ack_out   <= !rej; // RULE16
      end else if (state_reg == ST_EXEC && fop_done_in && op_ext_reg) begin
        ext_rsp_valid_out <= 1'b1; // RULE15
        ext_rsp_ack_out   <= fop_ok_in;
      end
    end
  end

  always_comb begin
    irq_set = 2'h0;
    if (take_self) begin
      irq_set[IRQ_REJ]  = rej;
      irq_set[IRQ_DONE] = !rej && !(cur.op == OP_BLK_ER || cur.op == OP_WRITE);
    end else if (state_reg == ST_EXEC && fop_done_in && !op_ext_reg) begin
      irq_set[IRQ_DONE] = fop_ok_in;
      irq_set[IRQ_REJ]  = !fop_ok_in;
    end
  end

  // set beats a same-cycle write-one-to-clear
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_st_reg <= IRQ_RST;
    end else if (wr_acc && paddr_in == OFS_IRQ_ST) begin
      irq_st_reg <= (irq_st_reg & ~pwdata_in[1:0]) | irq_set;
    end else begin
      irq_st_reg <= irq_st_reg | irq_set;
    end
  end

  assign irq_out = |(irq_st_reg & irq_msk_reg);

  // ---------------- assertions
  property p_active_hold;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      !session_entry |=> $stable(active_reg);
  endproperty
  a_active_hold: assert property (p_active_hold) else $error("flags changed mid session"); // RULE1

  property p_ce_issue;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      ($rose(fop_valid_out) && op_ext_reg && fop_out.op != OP_WRITE) |->
        !active_reg[FLG_CE];
  endproperty
  a_ce_issue: assert property (p_ce_issue) else $error("erase issued under erase lock"); // RULE2

  property p_ce_lock;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      (nv_wr_out && $past(nv_flags_in[FLG_CE])) |-> ((nv_wdata_out & $past(nv_flags_in)) ==
                                                     $past(nv_flags_in));
  endproperty
  a_ce_lock: assert property (p_ce_lock) else $error("flag cleared after erase lock"); // RULE3

  property p_blk_ext;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      ($rose(fop_valid_out) && op_ext_reg && fop_out.op == OP_BLK_ER) |->
        !active_reg[FLG_BE] && !active_reg[FLG_WR];
  endproperty
  a_blk_ext: assert property (p_blk_ext) else $error("block erase under lock"); // RULE4 RULE5

  property p_boot;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      $rose(fop_valid_out) && active_reg[FLG_BT] |->
        fop_out.op != OP_CHIP_ER && fop_out.addr > BOOT_HI;
  endproperty
  a_boot: assert property (p_boot) else $error("boot cluster op under boot lock"); // RULE6 RULE11

  property p_self_free;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      (take_self && (cur.op == OP_BLK_ER || cur.op == OP_WRITE) &&
       !(active_reg[FLG_BT] && touch)) |=> fop_valid_out ##0 !op_ext_reg;
  endproperty
  a_self_free: assert property (p_self_free) else $error("self op wrongly refused"); // RULE10

  property p_sec_set;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      (take && cur.op == OP_SEC_SET) |=>
        nv_wr_out && nv_wdata_out == ($past(nv_flags_in) | $past(cur.sec));
  endproperty
  a_sec_set: assert property (p_sec_set) else $error("security set not stored"); // RULE8

  property p_perm;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      nv_wr_out |-> (nv_wdata_out[FLG_CE] >= $past(nv_flags_in[FLG_CE])) &&
                    (nv_wdata_out[FLG_BT] >= $past(nv_flags_in[FLG_BT]));
  endproperty
  a_perm: assert property (p_perm) else $error("permanent flag cleared"); // RULE12

  sequence s_ce_ok;
    ce_done_ok && !nv_flags_in[FLG_CE];
  endsequence
  property p_ce_clear;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      s_ce_ok |=> nv_wr_out && !nv_wdata_out[FLG_BE] && !nv_wdata_out[FLG_WR];
  endproperty
  a_ce_clear: assert property (p_ce_clear) else $error("chip erase left locks"); // RULE9

  property p_self_no_clear;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      (nv_wr_out && !op_ext_reg && !$past(take)) |-> 1'b0;
  endproperty
  a_self_no_clear: assert property (p_self_no_clear) else $error("clear from self mode"); // RULE13

  property p_wr_ok;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      (take_ext && cur.op == OP_WRITE && !active_reg[FLG_WR] && !active_reg[FLG_BT]) |=>
        fop_valid_out;
  endproperty
  a_wr_ok: assert property (p_wr_ok) else $error("write refused under erase lock"); // RULE14

  sequence s_done_ext;
    state_reg == ST_EXEC && fop_done_in && op_ext_reg;
  endsequence
  property p_rsp;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      s_done_ext |=> ext_rsp_valid_out && ext_rsp_ack_out == $past(fop_ok_in);
  endproperty
  a_rsp: assert property (p_rsp) else $error("no response after operation"); // RULE15

  property p_nak;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      (take_ext && rej) |=> ext_rsp_valid_out && !ext_rsp_ack_out && !fop_valid_out;
  endproperty
  a_nak: assert property (p_nak) else $error("rejected command not nakked"); // RULE16

endmodule : fsg_gate
`default_nettype wire

//--- rtl/fsg_pkg.sv
// Purpose: constants and types for the flash security gate
// Assumes: one 50 MHz clock, APB register access, zero-wait slave
// Notes: prohibition flags live in an outside non-volatile store
//
// Functional notes
// (RULE1) new settings apply from next session
// (RULE2) chip-erase lock rejects external chip/block erase
// (RULE3) chip-erase lock forbids clearing any flag
// (RULE4) block-erase lock rejects external block erase
// (RULE5) write lock rejects external write, block erase
// (RULE6) boot lock rejects ops touching 0000H-0FFFH
// (RULE7) shipped state: all four flags clear
// (RULE8) flags set independently, both modes
// (RULE9) good chip erase clears block/write locks
// (RULE10) self mode ignores chip/block/write locks
// (RULE11) self mode still obeys boot lock
// (RULE12) chip-erase and boot locks are permanent
// (RULE13) only external chip erase clears locks
// (RULE14) external writes allowed under chip-erase lock
// (RULE15) every external command gets ack or nak
// (RULE16) rejected command leaves array untouched, naks
// (RULE17) flags kept in non-volatile storage
package fsg_pkg;

  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned ADDR_W      = 17;
  localparam int unsigned FLAG_W      = 4;

  // flag bit positions
  localparam int unsigned FLG_CE      = 0;
  localparam int unsigned FLG_BE      = 1;
  localparam int unsigned FLG_WR      = 2;
  localparam int unsigned FLG_BT      = 3;
  localparam logic [3:0]  FLAGS_RST   = 4'h0;

  // boot cluster upper bound; the cluster starts at the bottom of the array
  localparam logic [16:0] BOOT_HI     = 17'h00FFF;

  // command codes
  localparam logic [2:0]  OP_OTHER    = 3'h0;
  localparam logic [2:0]  OP_CHIP_ER  = 3'h1;
  localparam logic [2:0]  OP_BLK_ER   = 3'h2;
  localparam logic [2:0]  OP_WRITE    = 3'h3;
  localparam logic [2:0]  OP_SEC_SET  = 3'h4;

  // register byte offsets
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_CMD     = 8'h04;
  localparam logic [7:0]  OFS_ADDR    = 8'h08;
  localparam logic [7:0]  OFS_STATUS  = 8'h0C;
  localparam logic [7:0]  OFS_IRQ_ST  = 8'h10;
  localparam logic [7:0]  OFS_IRQ_MSK = 8'h14;

  // irq status bits
  localparam int unsigned IRQ_DONE    = 0;
  localparam int unsigned IRQ_REJ     = 1;
  localparam logic [1:0]  IRQ_RST     = 2'h0;

  typedef struct packed {
    logic [2:0]        op;
    logic [16:0]       addr;
    logic [3:0]        sec;
  } fsg_cmd_t;

  typedef struct packed {
    logic [2:0]        op;
    logic [16:0]       addr;
  } fsg_fop_t;

  typedef enum logic [0:0] {ST_IDLE, ST_EXEC} fsg_state_t;

endpackage : fsg_pkg

//--- testbench/fsg_far.sv
// Purpose: far side stand-in, nv flag cells and flash array engine
// Assumes: array op ends four cycles after it starts, always good
// Notes: flag cells ignore reset, so settings outlive it
`timescale 1ns/1ns
`default_nettype none
module fsg_far (
  input  wire logic       clk_in,
  input  wire logic       nv_wr_in,
  input  wire logic [3:0] nv_wdata_in,
  output logic      [3:0] nv_flags_out,
  input  wire logic       fop_valid_in,
  output logic            fop_done_out,
  output logic            fop_ok_out
);
  logic [1:0] cnt_reg;
  logic       sent_reg;
  initial begin
    nv_flags_out = 4'h0;
    cnt_reg = 2'h0;
    sent_reg = 1'b0;
    fop_done_out = 1'b0;
    fop_ok_out = 1'b0;
  end
  // no reset input: cells must keep their value
  always @(posedge clk_in) begin
    if (nv_wr_in) nv_flags_out <= nv_wdata_in;
  end
  always @(posedge clk_in) begin
    fop_done_out <= 1'b0;
    fop_ok_out <= 1'b0;
    if (!fop_valid_in) begin
      cnt_reg <= 2'h0;
      sent_reg <= 1'b0;
    end else if (!sent_reg) begin
      cnt_reg <= cnt_reg + 2'h1;
      if (cnt_reg == 2'h3) begin
        fop_done_out <= 1'b1;
        fop_ok_out <= 1'b1;
        sent_reg <= 1'b1;
      end
    end
  end
endmodule : fsg_far
`default_nettype wire

//--- testbench/testbench.sv
// Purpose: self-checking bench for the flash security gate
// Assumes: zero-wait APB slave, flags latched at session entry
// Notes: scenarios run in order because chip-erase and boot lock bits only ever grow
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import fsg_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic        ext_mode_in = 1'b0;
  logic        ext_cmd_valid_in = 1'b0;
  fsg_cmd_t    ext_cmd_in = '0;
  logic [31:0] prdata_out, q;
  logic        pready_out, pslverr_out, e, fop_seen = 1'b0;
  logic        ext_cmd_ready_out, ext_rsp_valid_out, ext_rsp_ack_out;
  logic [3:0]  nv_flags, nv_wdata;
  logic        nv_wr, fop_valid_out, fop_done, fop_ok, irq_out;
  fsg_fop_t    fop, fop_last;
  int          failures = 0;
  int          checked = 0;
  int          cycles = 0;

  always #10 clk_sys_in = ~clk_sys_in;

  fsg_gate DUT (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .ext_mode_in(ext_mode_in),
    .ext_cmd_valid_in(ext_cmd_valid_in), .ext_cmd_in(ext_cmd_in),
    .ext_cmd_ready_out(ext_cmd_ready_out), .ext_rsp_valid_out(ext_rsp_valid_out),
    .ext_rsp_ack_out(ext_rsp_ack_out), .nv_flags_in(nv_flags), .nv_wr_out(nv_wr),
    .nv_wdata_out(nv_wdata), .fop_valid_out(fop_valid_out), .fop_out(fop),
    .fop_done_in(fop_done), .fop_ok_in(fop_ok), .irq_out(irq_out));

  fsg_far far (.clk_in(clk_sys_in), .nv_wr_in(nv_wr), .nv_wdata_in(nv_wdata),
    .nv_flags_out(nv_flags), .fop_valid_in(fop_valid_out), .fop_done_out(fop_done),
    .fop_ok_out(fop_ok));

  // cleared on the edge a command is taken, set by any array op that follows
  always @(posedge clk_sys_in) begin
    if (ext_cmd_valid_in === 1'b1 && ext_cmd_ready_out === 1'b1) begin
      fop_seen <= 1'b0;
    end else if (fop_valid_out === 1'b1) begin
      fop_seen <= 1'b1;
      fop_last <= fop;
    end
  end

  task automatic print_verdict;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  // hang guard: whole run needs far fewer cycles
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    @(posedge clk_sys_in);
    while (pready_out !== 1'b1) @(posedge clk_sys_in);
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  task automatic session(input logic on);
    @(posedge clk_sys_in);
    ext_mode_in <= on;
    repeat (2) @(posedge clk_sys_in);
  endtask : session

  task automatic ext(input logic [2:0] op, input logic [16:0] a, input logic [3:0] s,
                     input logic ack);
    int n;
    @(posedge clk_sys_in);
    ext_cmd_valid_in <= 1'b1;
    ext_cmd_in <= '{op: op, addr: a, sec: s};
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (ext_cmd_ready_out !== 1'b1 && n < 50);
    ext_cmd_valid_in <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (ext_rsp_valid_out !== 1'b1 && n < 50);
    check({31'h0, ext_rsp_valid_out}, 32'h1);
    check({31'h0, ext_rsp_ack_out}, {31'h0, ack});
    check({31'h0, fop_seen}, {31'h0, ack && op != OP_SEC_SET});
    if (ack && op != OP_SEC_SET) check({12'h0, fop_last}, {12'h0, op, a});
  endtask : ext

  // self session entry is the rising edge of the mode bit
  task automatic self_enter;
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h1);
  endtask : self_enter

  task automatic self_cmd(input logic [2:0] op, input logic [16:0] a, input logic [3:0] s,
                          input logic [1:0] irq);
    int n;
    apb(1'b1, OFS_IRQ_ST, 32'h3);
    apb(1'b1, OFS_ADDR, {15'h0, a});
    apb(1'b1, OFS_CMD, {24'h0, s, 1'b0, op});
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (q[9:8] !== 2'h0 && n < 20);
    apb(1'b0, OFS_IRQ_ST, 32'h0);
    check(q & 32'h3, {30'h0, irq});
  endtask : self_cmd

  task automatic t_reset;
    apb(1'b0, OFS_STATUS, 32'h0);
    check(q & 32'hFF, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, e}, 32'h1);
    check(q, 32'h0);
    check({31'h0, irq_out}, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_ext_locks;
    session(1'b1);
    ext(OP_SEC_SET, 17'h0, 4'h6, 1'b1);
    ext(OP_BLK_ER, 17'h02000, 4'h0, 1'b1);
    session(1'b0);
    session(1'b1);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(q & 32'hF, 32'h6);
    ext(OP_BLK_ER, 17'h02000, 4'h0, 1'b0);
    ext(OP_WRITE, 17'h04000, 4'h0, 1'b0);
    ext(OP_CHIP_ER, 17'h0, 4'h0, 1'b1);
    apb(1'b0, OFS_STATUS, 32'h0);
    check((q >> 4) & 32'hF, 32'h0);
    ext(OP_SEC_SET, 17'h0, 4'h1, 1'b1);
    session(1'b0);
    session(1'b1);
    ext(OP_CHIP_ER, 17'h0, 4'h0, 1'b0);
    ext(OP_BLK_ER, 17'h06000, 4'h0, 1'b0);
    ext(OP_WRITE, 17'h04000, 4'h0, 1'b1);
    session(1'b0);
    $display("test ext locks done");
  endtask : t_ext_locks

  task automatic t_self;
    self_enter();
    self_cmd(OP_SEC_SET, 17'h0, 4'h6, 2'h1);
    self_enter();
    self_cmd(OP_BLK_ER, 17'h02000, 4'h0, 2'h1);
    self_cmd(OP_WRITE, 17'h04000, 4'h0, 2'h1);
    self_cmd(OP_CHIP_ER, 17'h0, 4'h0, 2'h2);
    self_cmd(OP_SEC_SET, 17'h0, 4'h8, 2'h1);
    self_cmd(OP_WRITE, 17'h00100, 4'h0, 2'h1);
    self_enter();
    self_cmd(OP_WRITE, 17'h00100, 4'h0, 2'h2);
    self_cmd(OP_BLK_ER, 17'h02000, 4'h0, 2'h1);
    // a write lands at the access edge, so irq is looked at one edge later
    apb(1'b1, OFS_IRQ_MSK, 32'h2);
    @(posedge clk_sys_in);
    check({31'h0, irq_out}, 32'h0);
    apb(1'b1, OFS_IRQ_MSK, 32'h1);
    @(posedge clk_sys_in);
    check({31'h0, irq_out}, 32'h1);
    apb(1'b1, OFS_IRQ_ST, 32'h1);
    @(posedge clk_sys_in);
    check({31'h0, irq_out}, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h0);
    $display("test self done");
  endtask : t_self

  task automatic t_final;
    session(1'b1);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(q & 32'hF, 32'hF);
    ext(OP_WRITE, 17'h00010, 4'h0, 1'b0);
    ext(OP_BLK_ER, 17'h02000, 4'h0, 1'b0);
    ext(OP_CHIP_ER, 17'h0, 4'h0, 1'b0);
    session(1'b0);
    @(posedge clk_sys_in);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    apb(1'b0, OFS_STATUS, 32'h0);
    check((q >> 4) & 32'hF, 32'hF);
    $display("test final done");
  endtask : t_final

  initial begin
    repeat (8) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    t_reset();
    t_ext_locks();
    t_self();
    t_final();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
